// File: rtl/sar_ctrl_pkg.sv
// Shared constants and types for the converter control port
// Operation
// - Parallel mode: error pin carries bit 11
// - External-clock read overrun: discard, pulse error
// - Bits 12 to 15 always driven
// - Busy high from start until result latched
// - Bits 0 to 10 enabled only when select, read low
// - Chip select gates external serial clock
// - Reset high aborts conversion
// - Power-down: finish conversion, then inhibit
// - Start falling edge: hold and convert
// - Impulse mode: start still low after acquisition
// - Reference-disable high switches reference off
// - Buffer-disable low enables reference buffer
// - Serial mode: external-clock select sets clock pin direction; parallel mode leaves the pin an input
// - Serial result shifted out MSB first
package sar_ctrl_pkg;
    // ----------------------------------------
    // Widths and timing
    // ----------------------------------------
    localparam int RESULT_W = 16;
    localparam int FIFO_DEPTH = 16;
    localparam int CLK_MHZ = 100;
    localparam int CONV_NS = 1000;
    localparam int CONV_CYC = (CONV_NS * CLK_MHZ) / 1000;
    localparam int ACQ_NS = 250;
    localparam int ACQ_CYC = (ACQ_NS * CLK_MHZ + 999) / 1000;
    localparam int INT_SCLK_DIV = 4;
    localparam int ERR_PULSE_CYC = 4;
    localparam int ERR_BIT = 11;
    localparam logic [15:0] RESULT_RESET = 16'h0000;

    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        logic serial_interface_select;
        logic external_clock_select;
        logic power_down_in;
        logic impulse_sel;
        logic fast_sel;
        logic internal_reference_off;
        logic reference_buffer_off;
    } cfg_t;

    typedef struct packed {
        logic [15:0] data_out;
        logic [15:0] data_oe_n;
        logic busy;
        logic incomplete_read_flag;
        logic sclk_out;
        logic sclk_oe_n;
        logic ref_on;
        logic buf_on;
        logic low_power;
    } pins_t;
endpackage

// File: rtl/result_fifo.sv
// Parameterised result FIFO with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none
module result_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_reg;
    logic [AW:0] rd_reg;
    logic full;
    logic empty;

    assign empty = (wr_reg == rd_reg);
    assign full = (wr_reg[AW-1:0] == rd_reg[AW-1:0]) && !empty;
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[rd_reg[AW-1:0]];

    always_ff @(posedge mclk) begin
        if (reset) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else begin
            if (in_valid && !full) begin
                mem[wr_reg[AW-1:0]] <= in_data;
                wr_reg <= wr_reg + 1'b1;
            end
            if (out_ready && !empty) begin
                rd_reg <= rd_reg + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// File: rtl/pin_sync.sv
// Two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 4
) (
    input wire logic mclk,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    // No reset: a pin held low across reset must not look like an edge
    always_ff @(posedge mclk) begin
        meta_reg <= async_in;
        sync_out <= meta_reg;
    end
endmodule
`default_nettype wire

// File: rtl/sar_ctrl.sv
// Conversion control and result output logic of the converter
`timescale 1ns/1ns
`default_nettype none
module sar_ctrl (
    input wire logic mclk,
    input wire logic reset,
    input wire sar_ctrl_pkg::cfg_t cfg,
    input wire logic convert_start_n,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic sclk_in,
    input wire logic [15:0] sample_in,
    output sar_ctrl_pkg::pins_t pins
);
    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    logic [3:0] raw;
    logic [3:0] syn;
    logic cnv_n_s;
    logic cs_n_s;
    logic rd_n_s;
    logic sclk_s;

    assign raw = {convert_start_n, cs_n, rd_n, sclk_in};
    assign cnv_n_s = syn[3];
    assign cs_n_s = syn[2];
    assign rd_n_s = syn[1];
    assign sclk_s = syn[0];

    pin_sync #(.WIDTH(4)) u_sync (
        .mclk(mclk),
        .async_in(raw),
        .sync_out(syn)
    );

    // ----------------------------------------
    // Result FIFO
    // ----------------------------------------
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [15:0] fifo_out_data;

    result_fifo #(
        .WIDTH(sar_ctrl_pkg::RESULT_W),
        .DEPTH(sar_ctrl_pkg::FIFO_DEPTH)
    ) u_fifo (
        .mclk(mclk),
        .reset(reset),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(sample_in),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef enum logic [1:0] {IDLE, CONV, ACQ} phase_t;

    typedef struct packed {
        phase_t phase;
        logic [15:0] cnt;
        logic cnv_prev;
        logic sclk_prev;
        logic [15:0] shift;
        logic [15:0] result;
        logic [4:0] bits_left;
        logic reading;
        logic [2:0] err_cnt;
        logic [1:0] div;
        logic sclk_int;
        logic pending;
        sar_ctrl_pkg::pins_t pins;
    } state_t;

    state_t s_reg;
    state_t s_next;
    logic start_edge;
    logic bus_en;
    logic ext_mode;
    logic ser_clk_rise;
    logic done;

    localparam int ERR_IDX = sar_ctrl_pkg::ERR_BIT;

    function automatic logic falling(input logic prev, input logic now);
        falling = prev && !now;
    endfunction

    always_comb begin
        s_next = s_reg;
        start_edge = falling(s_reg.cnv_prev, cnv_n_s);
        bus_en = !cs_n_s && !rd_n_s;
        ext_mode = cfg.serial_interface_select && cfg.external_clock_select;
        done = 1'b0;
        fifo_out_ready = 1'b0;
        s_next.cnv_prev = cnv_n_s;
        s_next.sclk_prev = sclk_s;
        // External edges count only with chip select low
        ser_clk_rise = ext_mode ? (!s_reg.sclk_prev && sclk_s && !cs_n_s)
            : (s_reg.div == 2'd3 && !s_reg.sclk_int && bus_en);
        s_next.div = s_reg.div + 2'd1;
        if (s_reg.div == 2'd3) begin
            s_next.sclk_int = !s_reg.sclk_int;
        end

        case (s_reg.phase)
            IDLE: begin
                // Power-down inhibits new starts only
                if (start_edge && !cfg.power_down_in) begin
                    s_next.phase = CONV;
                    s_next.cnt = 16'(sar_ctrl_pkg::CONV_CYC);
                end
            end
            CONV: begin
                s_next.cnt = s_reg.cnt - 16'd1;
                if (s_reg.cnt == 16'd1 && fifo_out_valid) begin
                    done = 1'b1;
                    fifo_out_ready = 1'b1;
                    s_next.result = fifo_out_data;
                    s_next.phase = ACQ;
                    s_next.cnt = 16'(sar_ctrl_pkg::ACQ_CYC);
                end else if (s_reg.cnt == 16'd1) begin
                    s_next.cnt = 16'd1;
                end
            end
            ACQ: begin
                s_next.cnt = s_reg.cnt - 16'd1;
                if (s_reg.cnt == 16'd1) begin
                    s_next.phase = IDLE;
                    // Impulse mode: level start after acquisition
                    if (cfg.impulse_sel && !cfg.fast_sel && !cnv_n_s
                        && !cfg.power_down_in) begin
                        s_next.phase = CONV;
                        s_next.cnt = 16'(sar_ctrl_pkg::CONV_CYC);
                    end else if (start_edge && !cfg.power_down_in) begin
                        s_next.phase = CONV;
                        s_next.cnt = 16'(sar_ctrl_pkg::CONV_CYC);
                    end
                end
            end
            default: s_next.phase = IDLE;
        endcase

        // Serial shifter
        if (done) begin
            if (ext_mode && s_reg.reading) begin
                s_next.err_cnt = 3'(sar_ctrl_pkg::ERR_PULSE_CYC);
            end
            s_next.shift = s_next.result;
            s_next.bits_left = 5'd16;
            s_next.reading = 1'b0;
        end else if (ser_clk_rise && s_reg.bits_left != 5'd0) begin
            s_next.shift = {s_reg.shift[14:0], 1'b0};
            s_next.bits_left = s_reg.bits_left - 5'd1;
            s_next.reading = (s_reg.bits_left != 5'd1);
        end
        if (s_reg.err_cnt != 3'd0 && !done) begin
            s_next.err_cnt = s_reg.err_cnt - 3'd1;
        end

        // Output pins
        s_next.pins.busy = (s_next.phase == CONV);
        s_next.pins.ref_on = !cfg.internal_reference_off;
        s_next.pins.buf_on = !cfg.reference_buffer_off;
        s_next.pins.low_power = cfg.power_down_in && s_next.phase != CONV;
        s_next.pins.data_out = s_next.result;
        s_next.pins.data_oe_n = bus_en ? 16'h0000 : 16'hffff;
        s_next.pins.data_oe_n[15:12] = 4'h0;
        s_next.pins.data_out[15:12] = s_next.result[15:12];
        s_next.pins.incomplete_read_flag = s_next.err_cnt != 3'd0;
        s_next.pins.sclk_out = s_reg.sclk_int;
        s_next.pins.sclk_oe_n = 1'b1;
        if (cfg.serial_interface_select) begin
            s_next.pins.data_out[8] = s_next.shift[15];
            s_next.pins.data_out[ERR_IDX] = s_next.err_cnt != 3'd0;
            s_next.pins.data_oe_n[ERR_IDX] = !ext_mode;
            s_next.pins.sclk_oe_n = cfg.external_clock_select;
        end else begin
            s_next.pins.incomplete_read_flag = 1'b0;
            s_next.pins.data_out[ERR_IDX] = s_next.result[ERR_IDX];
        end
        // Sample held as the conversion begins
        fifo_in_valid = (s_reg.phase != CONV) && (s_next.phase == CONV)
            && fifo_in_ready;
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            // Edge memory low: no false start after reset
            s_reg <= '0;
            s_reg.pins.data_oe_n <= 16'h0fff;
            s_reg.pins.sclk_oe_n <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign pins = s_reg.pins;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_busy_start;
        @(posedge mclk) disable iff (reset)
        (s_reg.phase == IDLE && start_edge && !cfg.power_down_in)
        |=> pins.busy;
    endproperty
    a_busy_start: assert property (p_busy_start)
        else $error("busy did not rise on start");

    property p_abort;
        @(posedge mclk) reset |=> !pins.busy && !pins.incomplete_read_flag;
    endproperty
    a_abort: assert property (p_abort)
        else $error("reset did not abort");

    property p_pd;
        @(posedge mclk) disable iff (reset)
        (s_reg.phase == IDLE && cfg.power_down_in) |=> !pins.busy;
    endproperty
    a_pd: assert property (p_pd)
        else $error("start taken in power-down");

    property p_msb;
        @(posedge mclk) disable iff (reset)
        done |=> pins.data_out[8] == s_reg.result[15]
            || !cfg.serial_interface_select;
    endproperty
    a_msb: assert property (p_msb)
        else $error("serial output not MSB first");

    property p_top_bits;
        @(posedge mclk) disable iff (reset) pins.data_oe_n[15:12] == 4'h0;
    endproperty
    a_top_bits: assert property (p_top_bits)
        else $error("upper bits not driven");

    property p_bus_en;
        @(posedge mclk) disable iff (reset)
        (cs_n_s || rd_n_s) |=> pins.data_oe_n[7:0] == 8'hff;
    endproperty
    a_bus_en: assert property (p_bus_en)
        else $error("bus enabled without select");

    property p_err;
        @(posedge mclk) disable iff (reset)
        (done && ext_mode && s_reg.reading) |=> pins.incomplete_read_flag
            ##4 !pins.incomplete_read_flag;
    endproperty
    a_err: assert property (p_err)
        else $error("error pulse wrong");

    property p_ref;
        @(posedge mclk) disable iff (reset)
        cfg.internal_reference_off ##1 cfg.internal_reference_off
            |-> !pins.ref_on;
    endproperty
    a_ref: assert property (p_ref)
        else $error("reference not off");

    property p_buf;
        @(posedge mclk) disable iff (reset)
        !cfg.reference_buffer_off ##1 !cfg.reference_buffer_off
            |-> pins.buf_on;
    endproperty
    a_buf: assert property (p_buf)
        else $error("buffer not on");

    property p_bit11;
        @(posedge mclk) disable iff (reset)
        !cfg.serial_interface_select ##1 !cfg.serial_interface_select
            |-> pins.data_out[11] == s_reg.result[11];
    endproperty
    a_bit11: assert property (p_bit11)
        else $error("bit 11 not on shared pin");

    property p_busy_hold;
        @(posedge mclk) disable iff (reset)
        (s_reg.phase == CONV && s_reg.cnt != 16'd1) |=> pins.busy;
    endproperty
    a_busy_hold: assert property (p_busy_hold)
        else $error("busy fell before conversion end");

    property p_busy_end;
        @(posedge mclk) disable iff (reset)
        (s_reg.phase == CONV && s_reg.cnt == 16'd1 && fifo_out_valid)
            |=> !pins.busy;
    endproperty
    a_busy_end: assert property (p_busy_end)
        else $error("busy did not fall at end");

    property p_idle_quiet;
        @(posedge mclk) disable iff (reset)
        (s_reg.phase == IDLE && !start_edge) |=> !pins.busy;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("busy rose without a start");

    property p_flag_par;
        @(posedge mclk) disable iff (reset)
        !cfg.serial_interface_select |=> !pins.incomplete_read_flag;
    endproperty
    a_flag_par: assert property (p_flag_par)
        else $error("error flag set in parallel mode");

    property p_sclk_dir;
        @(posedge mclk) disable iff (reset)
        (cfg.serial_interface_select && cfg.external_clock_select)
            |=> pins.sclk_oe_n;
    endproperty
    a_sclk_dir: assert property (p_sclk_dir)
        else $error("clock pin driven in external mode");

    property p_shift;
        @(posedge mclk) disable iff (reset)
        (ser_clk_rise && !done && s_reg.bits_left != 5'd0)
            |=> s_reg.shift[15] == $past(s_reg.shift[14]);
    endproperty
    a_shift: assert property (p_shift)
        else $error("serial shift out of order");

    property p_gate;
        @(posedge mclk) disable iff (reset)
        (ext_mode && cs_n_s && !done)
            |=> s_reg.bits_left == $past(s_reg.bits_left);
    endproperty
    a_gate: assert property (p_gate)
        else $error("serial clock not gated by select");

    property p_impulse;
        @(posedge mclk) disable iff (reset)
        (s_reg.phase == ACQ && s_reg.cnt == 16'd1 && cfg.impulse_sel
            && !cfg.fast_sel && !cnv_n_s && !cfg.power_down_in)
            |=> pins.busy;
    endproperty
    a_impulse: assert property (p_impulse)
        else $error("impulse restart missing");

    property p_err_cause;
        @(posedge mclk) disable iff (reset)
        $rose(pins.incomplete_read_flag) |-> $past(done);
    endproperty
    a_err_cause: assert property (p_err_cause)
        else $error("error flag without conversion end");

    property p_low_power;
        @(posedge mclk) disable iff (reset)
        (cfg.power_down_in && s_reg.phase == IDLE) |=> pins.low_power;
    endproperty
    a_low_power: assert property (p_low_power)
        else $error("low power not entered");
endmodule
`default_nettype wire

// File: verif/host_model.sv
// Host side model: parallel reads and clocked serial reads
`timescale 1ns/1ns
`default_nettype none
module host_model (
    input wire logic mclk,
    input wire logic par_rd,
    input wire logic ser_go,
    input wire logic [4:0] nbits,
    input wire logic sdata,
    output logic cs_n,
    output logic rd_n,
    output logic sclk,
    output logic [15:0] word,
    output logic done
);
    initial begin
        cs_n = 1'b1;
        rd_n = 1'b1;
        sclk = 1'b0;
        word = 16'h0000;
        done = 1'b0;
    end
    // ----------------------------------------
    // Frame engine, 160 ns serial clock
    // ----------------------------------------
    always begin
        @(negedge mclk);
        if (ser_go && !done) begin
            cs_n = 1'b0;
            rd_n = 1'b0;
            repeat (8) @(negedge mclk);
            for (int i = 0; i < nbits; i++) begin
                // Bit stands before the rising edge moves it on
                word = {word[14:0], sdata};
                sclk = 1'b1;
                repeat (8) @(negedge mclk);
                sclk = 1'b0;
                repeat (8) @(negedge mclk);
            end
            // Clock stands still between frames
            cs_n = 1'b1;
            rd_n = 1'b1;
            done = 1'b1;
        end else begin
            cs_n = !par_rd;
            rd_n = !par_rd;
            if (!ser_go) done = 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: verif/sar_adc_conversion_control_port_tb.sv
// Self-checking bench for the converter control port
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b, m) begin samples_checked++; if ((a) !== (b)) begin \
errors++; $display("CHECK FAILED %0t %s", $time, m); end end
module sar_adc_conversion_control_port_tb;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic convert_start_n = 1'b1;
    logic par_rd = 1'b0;
    logic ser_go = 1'b0;
    logic flag_seen = 1'b0;
    logic [4:0] nbits = 5'h10;
    logic [15:0] sample_in = 16'h0000;
    logic [15:0] word;
    logic cs_n, rd_n, sclk_in, done;
    sar_ctrl_pkg::cfg_t cfg = '0;
    sar_ctrl_pkg::pins_t pins;
    int errors = 0;
    int samples_checked = 0;
    int hi;
    always #5 mclk = ~mclk;
    sar_ctrl uut (.mclk(mclk), .reset(reset), .cfg(cfg),
        .convert_start_n(convert_start_n), .cs_n(cs_n), .rd_n(rd_n),
        .sclk_in(sclk_in), .sample_in(sample_in), .pins(pins));
    host_model host (.mclk(mclk), .par_rd(par_rd), .ser_go(ser_go),
        .nbits(nbits),
        .sdata(pins.data_oe_n[8] ? ~pins.data_out[8] : pins.data_out[8]),
        .cs_n(cs_n),
        .rd_n(rd_n), .sclk(sclk_in), .word(word), .done(done));
    always @(posedge mclk) begin
        if (pins.incomplete_read_flag === 1'b1) flag_seen <= 1'b1;
    end
    function automatic logic on_level(logic off);
        return ~off;
    endfunction
    task automatic cyc(int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic convert(logic hold, output int cnt);
        cnt = 0;
        sample_in = 16'($urandom);
        convert_start_n = 1'b0;
        for (int i = 0; i < 20 && pins.busy !== 1'b1; i++) cyc(1);
        if (!hold) convert_start_n = 1'b1;
        // Busy fall taken as data ready
        while (pins.busy === 1'b1 && cnt < 400) begin
            cyc(1);
            cnt++;
        end
        cyc(30);
    endtask
    task automatic wait_done();
        ser_go = 1'b1;
        for (int j = 0; j < 400 && done !== 1'b1; j++) cyc(1);
        ser_go = 1'b0;
        cyc(2);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        #200000;
        errors++;
        final_report();
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        hi = $urandom(65389);
        cyc(6);
        reset = 1'b0;
        cyc(4);
        `CHK(pins.busy, 1'b0, "busy after reset")
        `CHK(pins.incomplete_read_flag, 1'b0, "flag after reset")
        `CHK(pins.data_oe_n, 16'h0fff, "upper bits driven")
        for (int k = 0; k < 3; k++) begin
            convert(1'b0, hi);
            `CHK(hi, sar_ctrl_pkg::CONV_CYC, "busy width")
            par_rd = 1'b1;
            cyc(5);
            `CHK(pins.data_oe_n, 16'h0000, "bus enabled")
            `CHK(pins.data_out, sample_in, "parallel result")
            par_rd = 1'b0;
            cyc(5);
            `CHK(pins.data_oe_n, 16'h0fff, "bus released")
        end
        $display("test parallel done");
        convert_start_n = 1'b0;
        cyc(20);
        `CHK(pins.busy, 1'b1, "busy mid conversion")
        reset = 1'b1;
        cyc(1);
        reset = 1'b0;
        cyc(1);
        `CHK(pins.busy, 1'b0, "abort on reset")
        convert_start_n = 1'b1;
        cyc(30);
        $display("test reset abort done");
        cfg.power_down_in = 1'b1;
        cyc(4);
        `CHK(pins.low_power, 1'b1, "low power")
        convert_start_n = 1'b0;
        cyc(20);
        `CHK(pins.busy, 1'b0, "start inhibited")
        convert_start_n = 1'b1;
        cfg.power_down_in = 1'b0;
        cyc(30);
        $display("test power down done");
        for (int i = 0; i < 4; i++) begin
            {cfg.internal_reference_off, cfg.reference_buffer_off} = 2'(i);
            cyc(4);
            `CHK(pins.ref_on, on_level(cfg.internal_reference_off), "ref")
            `CHK(pins.buf_on, on_level(cfg.reference_buffer_off), "buf")
        end
        $display("test reference done");
        cfg.impulse_sel = 1'b1;
        convert(1'b1, hi);
        for (int j = 0; j < 60 && pins.busy !== 1'b1; j++) cyc(1);
        `CHK(pins.busy, 1'b1, "impulse restart")
        convert_start_n = 1'b1;
        for (int j = 0; j < 200 && pins.busy === 1'b1; j++) cyc(1);
        cfg.impulse_sel = 1'b0;
        cyc(30);
        {cfg.impulse_sel, cfg.fast_sel} = 2'b11;
        convert(1'b1, hi);
        `CHK(hi, sar_ctrl_pkg::CONV_CYC, "fast busy width")
        `CHK(pins.busy, 1'b0, "no restart in fast mode")
        convert_start_n = 1'b1;
        {cfg.impulse_sel, cfg.fast_sel} = 2'b00;
        cyc(30);
        $display("test impulse done");
        cfg.serial_interface_select = 1'b1;
        cfg.external_clock_select = 1'b1;
        cyc(4);
        `CHK(pins.sclk_oe_n, 1'b1, "clock pin input")
        convert(1'b0, hi);
        wait_done();
        `CHK(word, sample_in, "serial word")
        convert(1'b0, hi);
        nbits = 5'h08;
        wait_done();
        `CHK(word[7:0], sample_in[15:8], "half word")
        flag_seen = 1'b0;
        // Half read left open across the next conversion end
        convert(1'b0, hi);
        `CHK(flag_seen, 1'b1, "overrun flag")
        cfg.external_clock_select = 1'b0;
        cyc(4);
        `CHK(pins.sclk_oe_n, 1'b0, "clock pin output")
        $display("test serial done");
        final_report();
    end
endmodule
`default_nettype wire
